// File: logic/lcd_segment_driver.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcd_regs.svh"
module lcd_segment_driver
(
    input wire logic core_clk, // system clock, 20 MHz
    input wire logic nrst, // async reset, active low
    input wire logic clkEn, // freezes all state when low
    input wire logic crystalRefClock, // crystal reference tick
    input wire logic lcdModuleEnable, // module enable
    input wire logic [1:0] dutySelect, // 0 static, 1 third, 2 quarter
    input wire logic [2:0] baseClockDivide, // base clock divider select
    input wire logic fastChargeEnable, // fast charge option
    input wire logic [1:0] fastChargeLength, // 0:/32 1:/64 2,3:/128
    input wire logic lowCurrent, // high ladder resistance when set
    input wire logic porteLcdSelect, // frontplanes 11..18 to lcd
    input wire logic portcLowLcdSelect, // frontplanes 19..22 to lcd
    input wire logic portcHighLcdSelect, // frontplanes 23..26 to lcd
    input wire logic [135:0] segmentDataRegs, // 17 words of 8 bits
    output logic [7:0] backplaneTap, // taps for backplanes 0..2 and 3
    output logic [65:0] frontplaneTap, // taps for frontplanes 0..32
    output logic [32:0] frontplaneDriveEn, // pin owned by lcd
    output logic front0OrBack3IsBack, // shared pin acts as backplane 3
    output logic ladderDisconnect, // ladder cut from supply
    output logic ladderLowRes // low ladder resistance applied
);
    import lcd_pkg::*;

    typedef struct packed {
        lcd_phase_t phase;
        logic polarity;
        logic [7:0] fcCnt;
        logic fcActive;
        logic [7:0] bpTap;
        logic [65:0] fpTap;
        logic [32:0] fpEn;
        logic shareBack;
        logic disc;
        logic lowRes;
    } lcd_drv_state_t;

    lcd_drv_state_t s_q, s_d;
    logic baseTick;

    lcd_base_clock u_base (
        .core_clk(core_clk),
        .nrst(nrst),
        .clkEn(clkEn),
        .crystalRefClock(crystalRefClock),
        .baseClockDivide(baseClockDivide),
        .run(lcdModuleEnable),
        .baseTick(baseTick)
    );

    // index of the last backplane phase for the duty, 0 for static
    function automatic logic [1:0] lastPhase(input logic [1:0] duty);
        case (duty)
            `LCD_DUTY_STATIC: lastPhase = 2'h0;
            `LCD_DUTY_THIRD: lastPhase = 2'h2;
            default: lastPhase = 2'h3;
        endcase
    endfunction

    // phase index for the state encoding
    function automatic logic [1:0] phaseIdx(input lcd_phase_t p);
        case (p)
            LCD_PH_ST0: phaseIdx = 2'h0;
            LCD_PH_ST1: phaseIdx = 2'h1;
            LCD_PH_ST2: phaseIdx = 2'h2;
            LCD_PH_ST3: phaseIdx = 2'h3;
            default: phaseIdx = 2'h0;
        endcase
    endfunction

    // does backplane bp take part at this duty
    function automatic logic bpUsed(input logic [1:0] duty, input logic [1:0] bp);
        case (duty)
            `LCD_DUTY_STATIC: bpUsed = (bp == 2'h0);
            // third duty keeps off backplane 3: that pin is frontplane 0 then
            `LCD_DUTY_THIRD: bpUsed = (bp != 2'h3);
            default: bpUsed = 1'b1;
        endcase
    endfunction

    logic [1:0] curIdx;
    logic [1:0] curBp;
    logic [7:0] fcLimit;
    logic [3:0] segBits [0:32];
    lcd_tap_t bpNext [0:3];
    lcd_tap_t fpNext [0:32];
    logic [32:0] fpSel;
    logic quarterDuty;

    assign curIdx = phaseIdx(s_q.phase);
    // phases walk backplanes upward from 0, so the shared pin is free below quarter duty
    assign curBp = curIdx;
    // both upper duty codes mean quarter duty
    assign quarterDuty = dutySelect[1];

    // each data word carries two frontplanes, four bits apiece
    genvar g;
    generate
        for (g = 0; g < `LCD_NUM_FP; g++) begin : g_seg
            assign segBits[g] = segmentDataRegs[g*4 +: 4];
        end
    endgenerate

    // backplane taps: selected plane swings rails, other used planes mid, unused planes at supply
    generate
        for (g = 0; g < `LCD_NUM_BP; g++) begin : g_bp
            always_comb begin
                if (!bpUsed(dutySelect, 2'(g))) begin
                    bpNext[g] = `LCD_TAP_VLCD;
                end else if (dutySelect == `LCD_DUTY_STATIC) begin
                    bpNext[g] = s_q.polarity ? `LCD_TAP_V3 : `LCD_TAP_VLCD;
                end else if (curBp == 2'(g)) begin
                    bpNext[g] = s_q.polarity ? `LCD_TAP_V3 : `LCD_TAP_VLCD;
                end else begin
                    // idle planes sit a third away from either frontplane level
                    bpNext[g] = s_q.polarity ? `LCD_TAP_V1 : `LCD_TAP_V2;
                end
            end
        end
    endgenerate

    // frontplane taps: on opposes backplane, off sits near it
    generate
        for (g = 0; g < `LCD_NUM_FP; g++) begin : g_fp
            always_comb begin
                if (dutySelect == `LCD_DUTY_STATIC) begin
                    if (segBits[g][0]) begin
                        fpNext[g] = s_q.polarity ? `LCD_TAP_VLCD : `LCD_TAP_V3;
                    end else begin
                        fpNext[g] = s_q.polarity ? `LCD_TAP_V3 : `LCD_TAP_VLCD;
                    end
                end else if (segBits[g][curBp]) begin
                    fpNext[g] = s_q.polarity ? `LCD_TAP_VLCD : `LCD_TAP_V3;
                end else begin
                    // off segment sees only a third of the span against any backplane in use
                    fpNext[g] = s_q.polarity ? `LCD_TAP_V2 : `LCD_TAP_V1;
                end
            end
        end
    endgenerate

    // shared frontplanes only when the port select hands them over
    generate
        for (g = 0; g < `LCD_NUM_FP; g++) begin : g_sel
            if (g >= `LCD_FP_PORTE_LO && g < `LCD_FP_PORTC_LO) begin : g_pe
                assign fpSel[g] = porteLcdSelect;
            end else if (g >= `LCD_FP_PORTC_LO && g < `LCD_FP_PORTC_MID) begin : g_pcl
                assign fpSel[g] = portcLowLcdSelect;
            end else if (g >= `LCD_FP_PORTC_MID && g <= `LCD_FP_PORTC_HI) begin : g_pch
                assign fpSel[g] = portcHighLcdSelect;
            end else if (g == 0) begin : g_f0
                assign fpSel[g] = !quarterDuty;
            end else begin : g_ded
                assign fpSel[g] = 1'b1;
            end
        end
    endgenerate

    // fast charge window in crystal ticks after each base tick, 32..128
    always_comb begin
        case (fastChargeLength)
            2'h0: fcLimit = 8'h20;
            2'h1: fcLimit = 8'h40;
            default: fcLimit = 8'h80;
        endcase
    end

    // next state of the whole driver
    always_comb begin
        s_d = s_q;
        s_d.shareBack = quarterDuty;
        s_d.fpEn = fpSel;
        if (!lcdModuleEnable) begin
            s_d.phase = LCD_PH_ST0;
            s_d.polarity = 1'b0;
            s_d.fcCnt = 8'h0;
            s_d.fcActive = 1'b0;
            s_d.bpTap = '0; // all at supply tap
            s_d.fpTap = '0;
            s_d.disc = 1'b1;
            s_d.lowRes = 1'b0;
        end else begin
            s_d.disc = 1'b0;
            if (baseTick) begin
                // advance one backplane per base period
                if (curIdx >= lastPhase(dutySelect)) begin
                    s_d.phase = LCD_PH_ST0;
                    s_d.polarity = ~s_q.polarity;
                end else begin
                    case (s_q.phase)
                        LCD_PH_ST0: s_d.phase = LCD_PH_ST1;
                        LCD_PH_ST1: s_d.phase = LCD_PH_ST2;
                        LCD_PH_ST2: s_d.phase = LCD_PH_ST3;
                        default: s_d.phase = LCD_PH_ST0;
                    endcase
                end
                s_d.fcActive = fastChargeEnable; // every edge
                s_d.fcCnt = 8'h0;
            end else if (s_q.fcActive && crystalRefClock) begin
                // counted in crystal ticks; a base period is at least 2 of them
                if (s_q.fcCnt >= fcLimit - 8'h1) begin
                    s_d.fcActive = 1'b0;
                end else begin
                    s_d.fcCnt = s_q.fcCnt + 8'h1;
                end
            end
            for (int i = 0; i < `LCD_NUM_BP; i++) begin
                s_d.bpTap[i*2 +: 2] = bpNext[i];
            end
            for (int i = 0; i < `LCD_NUM_FP; i++) begin
                s_d.fpTap[i*2 +: 2] = fpSel[i] ? fpNext[i] : `LCD_TAP_VLCD;
            end
            s_d.lowRes = fastChargeEnable ? s_d.fcActive : ~lowCurrent;
        end
    end

    // single state register for the driver
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{phase: LCD_PH_ST0, disc: 1'b1, default: '0};
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

    assign backplaneTap = s_q.bpTap;
    assign frontplaneTap = s_q.fpTap;
    assign frontplaneDriveEn = s_q.fpEn;
    assign front0OrBack3IsBack = s_q.shareBack;
    assign ladderDisconnect = s_q.disc;
    assign ladderLowRes = s_q.lowRes;

    // disabled module leaves every backplane and frontplane tap at supply and ladder cut
    AST_DISABLED_BLANK: assert property (@(posedge core_clk) disable iff (!nrst)
        (clkEn && !lcdModuleEnable) |=> (backplaneTap == 8'h0 && frontplaneTap == 66'h0 && ladderDisconnect))
        else $error("disabled driver not blank");
    // enabled module connects the ladder
    AST_LADDER_ON: assert property (@(posedge core_clk) disable iff (!nrst)
        (nrst && clkEn && lcdModuleEnable) |=> !ladderDisconnect)
        else $error("ladder cut while enabled");
    // static duty keeps backplanes 1..3 at supply
    AST_STATIC_BP: assert property (@(posedge core_clk) disable iff (!nrst)
        (clkEn && dutySelect == `LCD_DUTY_STATIC) |=> backplaneTap[7:2] == 6'h0)
        else $error("unused backplane driven");
    // third duty leaves backplane 3 idle, its pin serves frontplane 0
    AST_THIRD_BP3: assert property (@(posedge core_clk) disable iff (!nrst)
        (clkEn && dutySelect == `LCD_DUTY_THIRD) |=> backplaneTap[7:6] == 2'h0)
        else $error("backplane 3 used at third duty");
    // shared pin role follows duty; the release edge still loads reset values
    AST_SHARED_PIN: assert property (@(posedge core_clk) disable iff (!nrst)
        (nrst && clkEn) |=> (front0OrBack3IsBack == $past(dutySelect[1])
                   && frontplaneDriveEn[0] != front0OrBack3IsBack))
        else $error("shared pin role wrong");
    // port e frontplanes released without select
    AST_PORTE: assert property (@(posedge core_clk) disable iff (!nrst)
        (clkEn && !porteLcdSelect) |=> frontplaneDriveEn[18:11] == 8'h0)
        else $error("port e pins taken");
    // polarity flips only at frame end, on a base tick
    AST_POLARITY: assert property (@(posedge core_clk) disable iff (!nrst)
        (clkEn && $changed(s_q.polarity) && lcdModuleEnable) |-> $past(baseTick))
        else $error("polarity changed off frame edge");
    // static frame is one base period
    AST_STATIC_FRAME: assert property (@(posedge core_clk) disable iff (!nrst)
        (clkEn && lcdModuleEnable && baseTick && dutySelect == `LCD_DUTY_STATIC
         && s_q.phase == LCD_PH_ST0) |=> s_q.phase == LCD_PH_ST0)
        else $error("static frame longer than one period");
    // fast charge not asserted when option off and low current requested
    AST_FC_OFF: assert property (@(posedge core_clk) disable iff (!nrst)
        (clkEn && lcdModuleEnable && !fastChargeEnable && lowCurrent) |=> !ladderLowRes)
        else $error("low resistance without fast charge");
endmodule // lcd_segment_driver
`default_nettype wire

// File: logic/lcd_regs.svh
`ifndef LCD_REGS_SVH
`define LCD_REGS_SVH
// segment and plane counts
`define LCD_NUM_FP 33
`define LCD_NUM_BP 4
`define LCD_NUM_DATA 17
// ladder tap encoding: 0 = supply, 1 = 2/3, 2 = 1/3, 3 = bias bottom
`define LCD_TAP_VLCD 2'h0
`define LCD_TAP_V1 2'h1
`define LCD_TAP_V2 2'h2
`define LCD_TAP_V3 2'h3
// duty select encoding
`define LCD_DUTY_STATIC 2'h0
`define LCD_DUTY_THIRD 2'h1
`define LCD_DUTY_QUARTER 2'h2
// shared frontplane ranges
`define LCD_FP_PORTE_LO 11
`define LCD_FP_PORTC_LO 19
`define LCD_FP_PORTC_MID 23
`define LCD_FP_PORTC_HI 26
// fast charge base dividers, in crystal reference ticks
`define LCD_FC_MIN_SHIFT 5
// reset values
`define LCD_DIV_RST 3'h0
`endif

// File: logic/lcd_pkg.sv
package lcd_pkg;
    typedef enum logic [1:0] {
        LCD_PH_ST0 = 2'b00,
        LCD_PH_ST1 = 2'b01,
        LCD_PH_ST2 = 2'b11,
        LCD_PH_ST3 = 2'b10
    } lcd_phase_t;
    typedef logic [1:0] lcd_tap_t;
endpackage

// File: logic/lcd_base_clock.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcd_regs.svh"
// base clock tick generator: divides the crystal reference enable
module lcd_base_clock (
    input wire logic core_clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic clkEn, // freezes state when low
    input wire logic crystalRefClock, // crystal reference tick, one cycle
    input wire logic [2:0] baseClockDivide, // divide 2^(n+1)
    input wire logic run, // module enabled
    output logic baseTick // one-cycle pulse per base period
);
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } lcd_bc_state_t;
    lcd_bc_state_t s_q, s_d;
    logic [7:0] limit;
    // divider selected by the three bit field
    always_comb begin
        limit = 8'((9'h2 << baseClockDivide) - 9'h1);
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!run) begin
            s_d.cnt = 8'h0;
        end else if (crystalRefClock) begin
            if (s_q.cnt >= limit) begin
                s_d.cnt = 8'h0;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 8'h1;
            end
        end
    end
    // single state register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end
    assign baseTick = s_q.tick;
endmodule // lcd_base_clock
`default_nettype wire

// File: test/lcd_glass_model.sv
`timescale 1ns/1ps
`default_nettype none
// glass model: reports what each bp/fp pair of the panel sees
module lcd_glass_model (
    input wire logic core_clk, // sample clock
    input wire logic glassClear, // restarts the charge tally
    input wire logic [7:0] backplaneTap, // bp taps
    input wire logic [65:0] frontplaneTap, // fp taps
    output logic [131:0] segLit, // pair sees the full ladder span
    output logic [131:0] segHalf, // pair sees two thirds of the span
    output logic [3:0] bpActive, // bp sits at an extreme tap
    output int dcSum // running charge on fp1 against bp0
);
    int d;
    initial dcSum = 0;
    // lit means opposite ends of the four-level ladder; mid taps give a third only
    always @(negedge core_clk) begin
        for (int b = 0; b < 4; b++) begin
            bpActive[b] <= backplaneTap[2*b+:2] inside {2'h0, 2'h3};
            for (int k = 0; k < 33; k++) begin
                d = int'(frontplaneTap[2*k+:2]) - int'(backplaneTap[2*b+:2]);
                segLit[4*k+b] <= (d == 3) || (d == -3);
                // one-third bias never puts two thirds across a pair in use
                segHalf[4*k+b] <= (d == 2) || (d == -2);
            end
        end
        // charge builds up unless polarity alternates between frames
        dcSum <= glassClear ? 0 : dcSum + int'(frontplaneTap[3:2]) - int'(backplaneTap[1:0]);
    end
endmodule // lcd_glass_model
`default_nettype wire

// File: test/lcd_segment_driver_bench.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_segment_driver_bench;
    import lcd_pkg::*;
    typedef struct {string nm; int kind; logic [135:0] exp;} lcd_note_t;
    logic core_clk, nrst, clkEn, crystalRefClock, lcdModuleEnable, fastChargeEnable, lowCurrent;
    logic porteLcdSelect, portcLowLcdSelect, portcHighLcdSelect, glassClear;
    logic [1:0] dutySelect, fastChargeLength;
    logic [2:0] baseClockDivide;
    logic [135:0] segmentDataRegs;
    logic [7:0] backplaneTap;
    logic [65:0] frontplaneTap;
    logic [32:0] frontplaneDriveEn;
    logic front0OrBack3IsBack, ladderDisconnect, ladderLowRes;
    logic [131:0] segLit, segHalf, expLit, usedPairs;
    logic [3:0] bpActive, seen;
    logic [31:0] meas, hi, cyc;
    int dcSum;
    int mismatches = 0;
    int check_count = 0;
    lcd_note_t notes[$];

    lcd_segment_driver dut (.core_clk(core_clk), .nrst(nrst), .clkEn(clkEn),
        .crystalRefClock(crystalRefClock), .lcdModuleEnable(lcdModuleEnable), .dutySelect(dutySelect),
        .baseClockDivide(baseClockDivide), .fastChargeEnable(fastChargeEnable),
        .fastChargeLength(fastChargeLength), .lowCurrent(lowCurrent), .porteLcdSelect(porteLcdSelect),
        .portcLowLcdSelect(portcLowLcdSelect), .portcHighLcdSelect(portcHighLcdSelect),
        .segmentDataRegs(segmentDataRegs), .backplaneTap(backplaneTap), .frontplaneTap(frontplaneTap),
        .frontplaneDriveEn(frontplaneDriveEn), .front0OrBack3IsBack(front0OrBack3IsBack),
        .ladderDisconnect(ladderDisconnect), .ladderLowRes(ladderLowRes));
    lcd_glass_model glass (.core_clk(core_clk), .glassClear(glassClear), .backplaneTap(backplaneTap),
        .frontplaneTap(frontplaneTap), .segLit(segLit), .segHalf(segHalf), .bpActive(bpActive), .dcSum(dcSum));

    initial begin
        core_clk = 0;
        forever #25 core_clk = ~core_clk;
    end

    function automatic logic [135:0] rnd();
        return 136'({$urandom, $urandom, $urandom, $urandom, $urandom});
    endfunction

    // only pairs wired on the glass at the duty under test are looked at
    function automatic logic [135:0] observe(int kind);
        case (kind)
            0: return 136'(backplaneTap);
            1: return 136'(frontplaneDriveEn);
            2: return 136'(ladderDisconnect);
            3: return 136'(ladderLowRes);
            4: return 136'(front0OrBack3IsBack);
            5: return 136'(segLit & usedPairs);
            8: return 136'(segHalf & usedPairs);
            7: return 136'(frontplaneTap);
            default: return 136'(meas);
        endcase
    endfunction

    task automatic compare(string nm, logic [135:0] exp, logic [135:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // called at a rising edge; the watcher compares at the following falling edge
    task automatic note(string nm, int kind, logic [135:0] exp);
        notes.push_back('{nm, kind, exp});
        @(negedge core_clk);
        #1;
    endtask

    // watcher: settled outputs are compared against every pending note, oldest first
    always @(negedge core_clk) begin
        lcd_note_t nt;
        while (notes.size() > 0) begin
            nt = notes.pop_front();
            compare(nt.nm, nt.exp, observe(nt.kind));
        end
    end

    // cycles from one rise of a probe to the next, and how long it stayed high
    task automatic measure(input int sel);
        logic prv;
        logic v;
        prv = 1;
        hi = 0;
        cyc = 0;
        repeat (3000) begin
            @(negedge core_clk);
            v = sel ? bpActive[0] : ladderLowRes;
            if (v && !prv) break;
            prv = v;
        end
        hi = 1;
        // the rise just seen must not count as the next one
        prv = 1;
        repeat (3000) begin
            @(negedge core_clk);
            cyc++;
            v = sel ? bpActive[0] : ladderLowRes;
            if (v && !prv) break;
            hi += 32'(v);
            prv = v;
        end
        #1;
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // watchdog sized well above the expected run of about 5000 cycles
    initial begin
        #2000000;
        mismatches++;
        test_done();
    end

    initial begin
        void'($urandom(94));
        nrst = 0; clkEn = 1; crystalRefClock = 1; lcdModuleEnable = 0; dutySelect = 0; glassClear = 0;
        baseClockDivide = 0; fastChargeEnable = 0; fastChargeLength = 0; lowCurrent = 0;
        {porteLcdSelect, portcLowLcdSelect, portcHighLcdSelect} = 3'h7;
        segmentDataRegs = 0;
        repeat (6) @(posedge core_clk);
        nrst <= 1;
        segmentDataRegs <= rnd();
        repeat (3) @(posedge core_clk);
        note("bp taps", 0, 0);
        note("fp taps", 7, 0);
        note("ladder cut", 2, 1);
        $display("test blank done");
        // pin ownership across duties and random port selects
        for (int i = 0; i < 9; i++) begin
            @(posedge core_clk);
            {porteLcdSelect, portcLowLcdSelect, portcHighLcdSelect} <= 3'($urandom);
            lcdModuleEnable <= 1;
            dutySelect <= 2'(i % 4);
            repeat (2) @(posedge core_clk);
            note("drive en", 1, 136'({6'h3f, {4{portcHighLcdSelect}}, {4{portcLowLcdSelect}},
                {8{porteLcdSelect}}, 10'h3ff, !dutySelect[1]}));
            note("shared is bp3", 4, 136'(dutySelect[1]));
            note("ladder cut", 2, 0);
        end
        $display("test pins done");
        // random segment data seen by the glass in every duty
        for (int du = 0; du < 3; du++) begin
            @(posedge core_clk);
            dutySelect <= 2'(du);
            segmentDataRegs <= rnd();
            {porteLcdSelect, portcLowLcdSelect, portcHighLcdSelect} <= 3'h7;
            seen = 0;
            // pairs present on the glass at this duty; bp3 takes the fp0 pin at quarter duty
            usedPairs = {33{du == 0 ? 4'h1 : du == 1 ? 4'h7 : 4'hf}};
            if (du == 2) usedPairs[3:0] = 4'h0;
            repeat (3) @(posedge core_clk);
            repeat (40) begin
                @(posedge core_clk);
                expLit = segmentDataRegs[131:0] & {33{bpActive}} & usedPairs;
                note("lit segments", 5, 136'(expLit));
                note("two third span", 8, 0);
                // a backplane in use leaves the supply tap at some point
                for (int b = 0; b < 4; b++) begin
                    seen[b] = seen[b] | (backplaneTap[2*b+:2] != 2'h0);
                end
            end
            meas = 32'(seen);
            note("bps used", 6, du == 0 ? 136'h1 : du == 1 ? 136'h7 : 136'hf);
        end
        @(posedge core_clk) glassClear <= 1;
        @(posedge core_clk) glassClear <= 0;
        repeat (200) @(posedge core_clk);
        meas = 32'(dcSum <= 24 && dcSum >= -24);
        note("dc balance", 6, 1);
        $display("test segments done");
        // frame length per duty and divider
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk);
            dutySelect <= i < 3 ? 2'h1 : 2'h2;
            baseClockDivide <= 3'(i % 3);
            measure(1);
            measure(1);
            meas = cyc;
            note("frame cycles", 6, 136'((i < 3 ? 3 : 4) * (2 << (i % 3))));
            meas = hi;
            note("period cycles", 6, 136'(2 << (i % 3)));
        end
        $display("test frame done");
        // fast charge window after each waveform edge
        for (int len = 0; len < 4; len++) begin
            @(posedge core_clk);
            baseClockDivide <= 3'h7;
            fastChargeEnable <= 1;
            lowCurrent <= 1;
            fastChargeLength <= 2'(len);
            measure(0);
            measure(0);
            meas = hi;
            note("fast charge", 6, 136'(32 << (len > 2 ? 2 : len)));
            meas = cyc;
            note("charge spacing", 6, 256);
        end
        for (int lc = 0; lc < 2; lc++) begin
            @(posedge core_clk);
            fastChargeEnable <= 0;
            lowCurrent <= lc[0];
            repeat (3) @(posedge core_clk);
            note("low res", 3, 136'(lc == 0));
        end
        $display("test charge done");
        @(posedge core_clk) lcdModuleEnable <= 0;
        repeat (3) @(posedge core_clk);
        note("bp taps", 0, 0);
        note("ladder cut", 2, 1);
        $display("test disable done");
        test_done();
    end
endmodule // lcd_segment_driver_bench
`default_nettype wire
